// [hdl/rss_defines.svh]
/*
 * Constants of the rolling shutter row sequencer: register map, field
 * positions, reset values, pin indices and blanking phase timing.
 * Assumes a 100 MHz sequencer clock and a 16-bit serial frame.
 */
// Behaviour
// RL1 - Separate readout and reset row pointers
// RL2 - Both pointers step on each row clock
// RL3 - Exposure equals pointer spacing in rows
// RL4 - Both-sides bit or nondestructive drives pointers together
// RL5 - Dual slope: full frame, then shutter exposure
// RL6 - Nondestructive: reset once, read many times
// RL7 - Controller supplies continuous pixel rate clock
// RL8 - Controller pulses frame start each frame
// RL9 - Row clock selects row, runs blanking, loads columns
// RL10 - Pulse timing set by serially written registers; here fixed by RSS_PHASE_CYC and RSS_CNT_ONE
// RL11 - Control word twelve bits, resets to 0x100
// RL12 - Bit 0 chooses double sampling or nondestructive
// RL13 - Bits 1-2 variant, ignored unless nondestructive
// RL14 - Bit 3 resets pixels before readout; here only in double sampling mode, ignored when nondestructive
// RL15 - Bit 4 shutter or both-sides addressing
// RL16 - Bits 8-9 column granularity, 5-6 calibration speed
// RL17 - Bit 7 enables continuous precharge
// RL18 - Bit 10 routes dark reference to outputs
// RL19 - Bit 11 holds all pixels in reset
// RL20 - Pixel pair count eleven bits, resets 0x200
// RL21 - Variant codes: mode/reset or read frame
// RL22 - Double sampling: sample, reset row, sample again
`ifndef RSS_DEFINES_SVH
`define RSS_DEFINES_SVH

`define RSS_ADDR_W      4
`define RSS_SEQ_W       12
`define RSS_PIX_W       11
`define RSS_FRAME_BITS  5'h10
`define RSS_REG_SEQ     4'h0
`define RSS_REG_PIX     4'h1
`define RSS_SEQ_RESET   12'h100
`define RSS_PIX_RESET   11'h200

`define RSS_B_NDR       0
`define RSS_B_VAR_LO    1
`define RSS_B_VAR_HI    2
`define RSS_B_RBLACK    3
`define RSS_B_BOTH      4
`define RSS_B_FCAL      5
`define RSS_B_LCAL      6
`define RSS_B_PRECH     7
`define RSS_B_GRAN_LO   8
`define RSS_B_GRAN_HI   9
`define RSS_B_BLACK     10
`define RSS_B_RALL      11

`define RSS_ROW_W       12
`define RSS_ROWS        12'hBC6

`define RSS_PINS        5
`define RSS_PIN_SCLK    0
`define RSS_PIN_SDATA   1
`define RSS_PIN_LOAD    2
`define RSS_PIN_FSTART  3
`define RSS_PIN_RCLK    4

`define RSS_CLK_NS      10
`define RSS_PHASE_NS    50
`define RSS_PHASE_CYC   (4'((`RSS_PHASE_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS))
`define RSS_CNT_ONE     4'h1

`endif

// [hdl/rss_pkg.sv]
/*
 * Types of the rolling shutter row sequencer.
 * Assumes rss_defines.svh is included by every user.
 */
`include "rss_defines.svh"
package rss_pkg;
    typedef enum logic [2:0] {
        PH_IDLE     = 3'h0,
        PH_SYNC     = 3'h1,
        PH_PRE_RST  = 3'h2,
        PH_SAMP_SIG = 3'h3,
        PH_ROW_RST  = 3'h4,
        PH_SAMP_RST = 3'h5,
        PH_COL_LOAD = 3'h6
    } rss_phase_e;

    typedef struct packed {
        logic [`RSS_ADDR_W+`RSS_SEQ_W-1:0] shift;
        logic [4:0]                        cnt;
        logic                              stb;
        logic [`RSS_ADDR_W-1:0]            addr;
        logic [`RSS_SEQ_W-1:0]             data;
    } rss_ser_s;

    typedef struct packed {
        logic [`RSS_ROW_W-1:0] ptr;
    } rss_ptr_s;
endpackage

// [hdl/rss_row_ptr.sv]
/*
 * One row pointer: loads at frame start, steps on each row clock and
 * wraps at the last row. Assumes load and step from the same clock.
 */
`timescale 1ns/1ps
`include "rss_defines.svh"
module rss_row_ptr (
    input  wire logic                  clk_in,
    input  wire logic                  rst_n_in,
    input  wire logic                  load_in,
    input  wire logic [`RSS_ROW_W-1:0] load_val_in,
    input  wire logic                  step_in,
    output logic      [`RSS_ROW_W-1:0] ptr_out
);
    rss_pkg::rss_ptr_s s_r, s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (load_in) begin
            s_nxt.ptr = load_val_in;
        end else if (step_in) begin
            s_nxt.ptr = (s_r.ptr == `RSS_ROWS - 12'h001) ? 12'h000 : s_r.ptr + 12'h001; // RL2
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ptr_out = s_r.ptr;
endmodule

// [hdl/rss_ser_rx.sv]
/*
 * Three-wire serial receiver: shifts address and data MSB first on
 * serial clock rises, issues one write on the load rise.
 * Assumes inputs already synchronised and edge detected.
 */
`timescale 1ns/1ps
`include "rss_defines.svh"
module rss_ser_rx (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic sclk_rise_in,
    input  wire logic sdata_in,
    input  wire logic load_rise_in,
    rss_wr_if.src     wr
);
    rss_pkg::rss_ser_s s_r, s_nxt;

    always_comb begin
        s_nxt     = s_r;
        s_nxt.stb = 1'b0;
        if (load_rise_in) begin
            // Short or long frames are dropped, not half applied
            if (s_r.cnt == `RSS_FRAME_BITS) begin
                s_nxt.stb  = 1'b1; // RL10
                s_nxt.addr = s_r.shift[`RSS_ADDR_W+`RSS_SEQ_W-1:`RSS_SEQ_W];
                s_nxt.data = s_r.shift[`RSS_SEQ_W-1:0];
            end
            s_nxt.cnt = 5'h00;
        end else if (sclk_rise_in) begin
            s_nxt.shift = {s_r.shift[`RSS_ADDR_W+`RSS_SEQ_W-2:0], sdata_in};
            if (s_r.cnt != 5'h1F) begin
                s_nxt.cnt = s_r.cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wr.wr_stb  = s_r.stb;
    assign wr.wr_addr = s_r.addr;
    assign wr.wr_data = s_r.data;
endmodule

// [hdl/rss_top.sv]
/*
 * Rolling shutter row sequencer: register bank written over the
 * three-wire serial port, readout and reset row pointers, and the
 * per-row blanking sequence that drives the array row lines.
 * Assumes the controller drives the serial pins, frame start and row
 * clock as slow pins; the sequencer clock is the pixel rate clock.
 */
`timescale 1ns/1ps
`include "rss_defines.svh"
module rss_top (
    input  wire logic                  CLK_IN,
    input  wire logic                  RESET_N_IN,
    input  wire logic                  SER_CLK_IN,
    input  wire logic                  SER_DATA_IN,
    input  wire logic                  SER_LOAD_IN,
    input  wire logic                  FRAME_START_IN,
    input  wire logic                  ROW_CLOCK_IN,
    input  wire logic [`RSS_ROW_W-1:0] EXPOSURE_ROWS_IN,
    input  wire logic                  DUAL_SLOPE_IN,
    output logic      [`RSS_ROW_W-1:0] READ_ROW_OUT,
    output logic      [`RSS_ROW_W-1:0] RESET_ROW_OUT,
    output logic                       BOTH_SIDES_OUT,
    output logic                       ROW_SELECT_OUT,
    output logic                       SAMPLE_SIGNAL_OUT,
    output logic                       SAMPLE_RESET_OUT,
    output logic                       READ_ROW_RESET_OUT,
    output logic                       SHUTTER_RESET_OUT,
    output logic                       LOW_RESET_LEVEL_OUT,
    output logic                       COLUMN_LOAD_OUT,
    output logic      [`RSS_PIX_W-1:0] ROW_PIXEL_PAIR_COUNT_OUT,
    output logic                       NONDESTRUCTIVE_SELECT_OUT,
    output logic      [1:0]            MULTI_READ_VARIANT_OUT,
    output logic                       FRAME_CAL_SLOW_OUT,
    output logic                       LINE_CAL_SLOW_OUT,
    output logic                       CONTINUOUS_PRECHARGE_OUT,
    output logic                       COLUMN_CLOCK_GRANULARITY_LOW_OUT,
    output logic                       COLUMN_CLOCK_GRANULARITY_HIGH_OUT,
    output logic                       DARK_REFERENCE_OUT,
    output logic                       RESET_ALL_PIXELS_OUT
);

    ////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [`RSS_PINS-1:0]   sync1;
        logic [`RSS_PINS-1:0]   sync2;
        logic [`RSS_PINS-1:0]   prev;
        logic [`RSS_SEQ_W-1:0]  ctrl;
        logic [`RSS_PIX_W-1:0]  pairs;
        rss_pkg::rss_phase_e    phase;
        logic [3:0]             cnt;
        logic                   row_sel;
        logic                   samp_sig;
        logic                   samp_rst;
        logic                   read_rst;
        logic                   shut_rst;
        logic                   low_lvl;
        logic                   col_load;
        logic [`RSS_PIX_W-1:0]  col_count;
    } rss_top_s;

    rss_top_s              s_r;
    rss_top_s              s_nxt;
    logic                  rst_meta_r;
    logic                  rst_sync_r;
    logic [`RSS_PINS-1:0]  rise;
    logic                  frame_go;
    logic                  row_go;
    logic                  nondestructive_select;
    logic                  read_frame;
    logic                  both_sides;
    logic [`RSS_ROW_W-1:0] exposure;
    logic [`RSS_ROW_W-1:0] load_val [2];
    logic [`RSS_ROW_W-1:0] ptr      [2];

    rss_wr_if wr_bus ();

    ////////////////////////////////////////////////////////////////////
    // Reset release

    // Assertion is immediate, release is clocked to avoid recovery hazards
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Phase sequencing

    function automatic rss_pkg::rss_phase_e next_phase(
        input rss_pkg::rss_phase_e cur,
        input logic                nd,
        input logic                rd_only,
        input logic                pre_rst
    );
        rss_pkg::rss_phase_e nx;
        nx = rss_pkg::PH_IDLE;
        unique case (cur)
            rss_pkg::PH_IDLE: begin
                nx = rss_pkg::PH_SYNC;
            end
            rss_pkg::PH_SYNC: begin
                if (nd) begin
                    // Read frames never reset; reset frames sample reset level
                    nx = rd_only ? rss_pkg::PH_SAMP_SIG : rss_pkg::PH_ROW_RST; // RL6 RL21
                end else begin
                    nx = pre_rst ? rss_pkg::PH_PRE_RST : rss_pkg::PH_SAMP_SIG; // RL14
                end
            end
            rss_pkg::PH_PRE_RST: begin
                nx = rss_pkg::PH_SAMP_SIG;
            end
            rss_pkg::PH_SAMP_SIG: begin
                nx = nd ? rss_pkg::PH_COL_LOAD : rss_pkg::PH_ROW_RST; // RL22
            end
            rss_pkg::PH_ROW_RST: begin
                nx = rss_pkg::PH_SAMP_RST; // RL22
            end
            rss_pkg::PH_SAMP_RST: begin
                nx = rss_pkg::PH_COL_LOAD;
            end
            rss_pkg::PH_COL_LOAD: begin
                nx = rss_pkg::PH_IDLE;
            end
            default: begin
                nx = rss_pkg::PH_IDLE;
            end
        endcase
        return nx;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Decodes of the pin edges and the control word

    assign rise       = s_r.sync2 & ~s_r.prev;
    assign frame_go   = rise[`RSS_PIN_FSTART]; // RL8
    assign row_go     = rise[`RSS_PIN_RCLK] & ~frame_go; // RL9
    assign nondestructive_select        = s_r.ctrl[`RSS_B_NDR]; // RL12
    // Variant only matters in nondestructive mode
    assign read_frame = nondestructive_select & s_r.ctrl[`RSS_B_VAR_LO]; // RL13 RL21
    assign both_sides = s_r.ctrl[`RSS_B_BOTH] | nondestructive_select; // RL4 RL15

    // Spacing clamped so the reset pointer stays inside the array
    assign exposure = (EXPOSURE_ROWS_IN >= `RSS_ROWS) ? `RSS_ROWS - 12'h001
                                                      : EXPOSURE_ROWS_IN; // RL3

    assign load_val[0] = 12'h000;
    // Both-sides addressing keeps the two pointers on the same row
    assign load_val[1] = both_sides ? 12'h000 : exposure; // RL3 RL4

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_nxt       = s_r;
        s_nxt.sync1 = {ROW_CLOCK_IN, FRAME_START_IN, SER_LOAD_IN, SER_DATA_IN, SER_CLK_IN};
        s_nxt.sync2 = s_r.sync1;
        s_nxt.prev  = s_r.sync2;

        if (wr_bus.wr_stb) begin
            unique case (wr_bus.wr_addr)
                `RSS_REG_SEQ: begin
                    s_nxt.ctrl = wr_bus.wr_data; // RL10 RL11
                end
                `RSS_REG_PIX: begin
                    s_nxt.pairs = wr_bus.wr_data[`RSS_PIX_W-1:0]; // RL20
                end
                default: begin
                    s_nxt.ctrl = s_r.ctrl;
                end
            endcase
        end

        if (frame_go) begin
            s_nxt.phase = rss_pkg::PH_IDLE;
            s_nxt.cnt   = 4'h0;
        end else if (row_go) begin
            // A new row clock restarts blanking even mid-sequence
            s_nxt.phase = rss_pkg::PH_SYNC; // RL9
            s_nxt.cnt   = `RSS_PHASE_CYC;
        end else if (s_r.phase != rss_pkg::PH_IDLE) begin
            if (s_r.cnt > `RSS_CNT_ONE) begin
                s_nxt.cnt = s_r.cnt - `RSS_CNT_ONE;
            end else begin
                s_nxt.phase = next_phase(s_r.phase, nondestructive_select, read_frame,
                                         s_r.ctrl[`RSS_B_RBLACK]);
                s_nxt.cnt   = (s_nxt.phase == rss_pkg::PH_COL_LOAD) ? `RSS_CNT_ONE
                                                                     : `RSS_PHASE_CYC;
            end
        end

        s_nxt.row_sel  = (s_nxt.phase == rss_pkg::PH_PRE_RST)
                       | (s_nxt.phase == rss_pkg::PH_SAMP_SIG)
                       | (s_nxt.phase == rss_pkg::PH_ROW_RST)
                       | (s_nxt.phase == rss_pkg::PH_SAMP_RST);
        s_nxt.samp_sig = (s_nxt.phase == rss_pkg::PH_SAMP_SIG); // RL22
        s_nxt.samp_rst = (s_nxt.phase == rss_pkg::PH_SAMP_RST); // RL22
        s_nxt.read_rst = (s_nxt.phase == rss_pkg::PH_ROW_RST)
                       | (s_nxt.phase == rss_pkg::PH_PRE_RST); // RL14 RL22
        // Shutter row is reset only when the pointers are apart
        s_nxt.shut_rst = (s_nxt.phase == rss_pkg::PH_ROW_RST) & ~both_sides; // RL1 RL3
        // Dual slope: shutter reset at the lower level, readout at full
        s_nxt.low_lvl  = s_nxt.shut_rst & DUAL_SLOPE_IN; // RL5
        s_nxt.col_load = (s_nxt.phase == rss_pkg::PH_COL_LOAD); // RL9
        if (s_nxt.col_load) begin
            s_nxt.col_count = s_r.pairs; // RL20
        end
    end

    always_ff @(posedge CLK_IN or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            s_r       <= '0;
            s_r.ctrl  <= `RSS_SEQ_RESET; // RL11
            s_r.pairs <= `RSS_PIX_RESET; // RL20
            s_r.phase <= rss_pkg::PH_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Serial register port and row pointers

    rss_ser_rx u_ser (
        .clk_in       (CLK_IN),
        .rst_n_in     (rst_sync_r),
        .sclk_rise_in (rise[`RSS_PIN_SCLK]),
        .sdata_in     (s_r.sync2[`RSS_PIN_SDATA]),
        .load_rise_in (rise[`RSS_PIN_LOAD]),
        .wr           (wr_bus.src)
    );

    // Index 0 is the readout pointer, index 1 the shutter reset pointer
    for (genvar i = 0; i < 2; i++) begin : g_ptr
        rss_row_ptr u_ptr (
            .clk_in      (CLK_IN),
            .rst_n_in    (rst_sync_r),
            .load_in     (frame_go),
            .load_val_in (load_val[i]),
            .step_in     (row_go), // RL2
            .ptr_out     (ptr[i])
        ); // RL1
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    assign READ_ROW_OUT                      = ptr[0];
    assign RESET_ROW_OUT                     = ptr[1];
    assign BOTH_SIDES_OUT                    = both_sides; // RL4
    assign ROW_SELECT_OUT                    = s_r.row_sel;
    assign SAMPLE_SIGNAL_OUT                 = s_r.samp_sig;
    assign SAMPLE_RESET_OUT                  = s_r.samp_rst;
    assign READ_ROW_RESET_OUT                = s_r.read_rst;
    assign SHUTTER_RESET_OUT                 = s_r.shut_rst;
    assign LOW_RESET_LEVEL_OUT               = s_r.low_lvl;
    assign COLUMN_LOAD_OUT                   = s_r.col_load;
    assign ROW_PIXEL_PAIR_COUNT_OUT          = s_r.col_count;
    assign NONDESTRUCTIVE_SELECT_OUT         = nondestructive_select; // RL12
    assign MULTI_READ_VARIANT_OUT            = s_r.ctrl[`RSS_B_VAR_HI:`RSS_B_VAR_LO]; // RL13
    assign FRAME_CAL_SLOW_OUT                = s_r.ctrl[`RSS_B_FCAL]; // RL16
    assign LINE_CAL_SLOW_OUT                 = s_r.ctrl[`RSS_B_LCAL]; // RL16
    assign CONTINUOUS_PRECHARGE_OUT          = s_r.ctrl[`RSS_B_PRECH]; // RL17
    assign COLUMN_CLOCK_GRANULARITY_LOW_OUT  = s_r.ctrl[`RSS_B_GRAN_LO]; // RL16
    assign COLUMN_CLOCK_GRANULARITY_HIGH_OUT = s_r.ctrl[`RSS_B_GRAN_HI]; // RL16
    assign DARK_REFERENCE_OUT                = s_r.ctrl[`RSS_B_BLACK]; // RL18
    assign RESET_ALL_PIXELS_OUT              = s_r.ctrl[`RSS_B_RALL]; // RL19

endmodule

// [hdl/rss_wr_if.sv]
/*
 * Register write path from the serial receiver to the sequencer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`include "rss_defines.svh"
interface rss_wr_if;
    logic                   wr_stb;
    logic [`RSS_ADDR_W-1:0] wr_addr;
    logic [`RSS_SEQ_W-1:0]  wr_data;
    modport src (output wr_stb, output wr_addr, output wr_data);
    modport dst (input wr_stb, input wr_addr, input wr_data);
endinterface

// [verification/rss_ctrl_model.sv]
/*
 * Camera controller model: serial register upload, frame start and
 * row clock pulses. Assumes calls from one process, each entered just
 * after a rising edge of clk_in.
 */
`timescale 1ns/1ps
module rss_ctrl_model (
    input  wire logic clk_in,
    output logic      sclk_out,
    output logic      sdata_out,
    output logic      load_out,
    output logic      fstart_out,
    output logic      rclk_out
);
    initial begin
        sclk_out   = 1'h0;
        sdata_out  = 1'h0;
        load_out   = 1'h0;
        fstart_out = 1'h0;
        rclk_out   = 1'h0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk_in);
    endtask
////////////////////////////////////////////////////////////////////////
    // Three clocks per level so the pin synchroniser sees each one
    task automatic wr(input logic [3:0] a, input logic [11:0] d);
        logic [15:0] f;
        f = {a, d};
        for (int i = 15; i >= 0; i--) begin
            sclk_out  <= 1'h0;
            sdata_out <= f[i];
            hold(3);
            sclk_out <= 1'h1;
            hold(3);
        end
        sclk_out  <= 1'h0;
        sdata_out <= ~f[0];
        hold(3);
        load_out <= 1'h1;
        hold(3);
        load_out <= 1'h0;
        hold(6);
    endtask

    task automatic fs();
        fstart_out <= 1'h1;
        hold(4);
        fstart_out <= 1'h0;
        hold(4);
    endtask

    task automatic row();
        rclk_out <= 1'h1;
        hold(4);
        rclk_out <= 1'h0;
        hold(1);
    endtask
endmodule

// [verification/rss_monitor.sv]
/*
 * Checker of the row sequencer top ports: pulse shapes, phase order,
 * pointer stepping and both-sides behaviour.
 * Assumes it is bound onto rss_top, one clock, raw active-low reset.
 */
`timescale 1ns/1ps
`include "rss_defines.svh"
module rss_monitor (
    input wire logic                  CLK_IN,
    input wire logic                  RESET_N_IN,
    input wire logic [`RSS_ROW_W-1:0] READ_ROW_OUT,
    input wire logic [`RSS_ROW_W-1:0] RESET_ROW_OUT,
    input wire logic                  BOTH_SIDES_OUT,
    input wire logic                  ROW_SELECT_OUT,
    input wire logic                  SAMPLE_SIGNAL_OUT,
    input wire logic                  SAMPLE_RESET_OUT,
    input wire logic                  READ_ROW_RESET_OUT,
    input wire logic                  SHUTTER_RESET_OUT,
    input wire logic                  LOW_RESET_LEVEL_OUT,
    input wire logic                  COLUMN_LOAD_OUT,
    input wire logic                  NONDESTRUCTIVE_SELECT_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
////////////////////////////////////////////////////////////////////////
    property p_col_pulse;
        COLUMN_LOAD_OUT |=> !COLUMN_LOAD_OUT;
    endproperty
    a_col_pulse: assert property (p_col_pulse)
        else $error("column load wider than one cycle");
    property p_col_after;
        $rose(COLUMN_LOAD_OUT) |-> $past(SAMPLE_RESET_OUT) || $past(SAMPLE_SIGNAL_OUT);
    endproperty
    a_col_after: assert property (p_col_after)
        else $error("column load not right after a sample phase");
    property p_nd_both;
        NONDESTRUCTIVE_SELECT_OUT |-> BOTH_SIDES_OUT;
    endproperty
    a_nd_both: assert property (p_nd_both)
        else $error("nondestructive without both-sides drive");
    property p_shut_both;
        BOTH_SIDES_OUT && $past(BOTH_SIDES_OUT) |-> !SHUTTER_RESET_OUT;
    endproperty
    a_shut_both: assert property (p_shut_both)
        else $error("shutter reset while both-sides");
    property p_low_level;
        LOW_RESET_LEVEL_OUT |-> SHUTTER_RESET_OUT;
    endproperty
    a_low_level: assert property (p_low_level)
        else $error("low reset level outside shutter reset");
    property p_step;
        READ_ROW_OUT == $past(READ_ROW_OUT) + 12'h001
            |-> RESET_ROW_OUT == $past(RESET_ROW_OUT) + 12'h001 || RESET_ROW_OUT == 12'h000;
    endproperty
    a_step: assert property (p_step)
        else $error("pointers did not step together");
    property p_rst_before;
        $rose(SAMPLE_RESET_OUT) |-> $past(READ_ROW_RESET_OUT) && !SAMPLE_SIGNAL_OUT;
    endproperty
    a_rst_before: assert property (p_rst_before)
        else $error("reset sample not preceded by row reset");
    property p_sig_len;
        $rose(SAMPLE_SIGNAL_OUT) |-> SAMPLE_SIGNAL_OUT [*5] ##1 !SAMPLE_SIGNAL_OUT;
    endproperty
    a_sig_len: assert property (p_sig_len)
        else $error("signal sample phase not five cycles");
    property p_sel;
        SAMPLE_SIGNAL_OUT || SAMPLE_RESET_OUT || READ_ROW_RESET_OUT |-> ROW_SELECT_OUT;
    endproperty
    a_sel: assert property (p_sel)
        else $error("row strobe without row select");
    c_col: cover property (COLUMN_LOAD_OUT);
    c_low: cover property (LOW_RESET_LEVEL_OUT);
    c_nd: cover property (NONDESTRUCTIVE_SELECT_OUT && SAMPLE_RESET_OUT);
endmodule

bind rss_top rss_monitor rss_monitor_inst (
    .CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .READ_ROW_OUT(READ_ROW_OUT),
    .RESET_ROW_OUT(RESET_ROW_OUT), .BOTH_SIDES_OUT(BOTH_SIDES_OUT),
    .ROW_SELECT_OUT(ROW_SELECT_OUT), .SAMPLE_SIGNAL_OUT(SAMPLE_SIGNAL_OUT),
    .SAMPLE_RESET_OUT(SAMPLE_RESET_OUT), .READ_ROW_RESET_OUT(READ_ROW_RESET_OUT),
    .SHUTTER_RESET_OUT(SHUTTER_RESET_OUT), .LOW_RESET_LEVEL_OUT(LOW_RESET_LEVEL_OUT),
    .COLUMN_LOAD_OUT(COLUMN_LOAD_OUT),
    .NONDESTRUCTIVE_SELECT_OUT(NONDESTRUCTIVE_SELECT_OUT));

// [verification/tb_top.sv]
/*
 * Testbench of the row sequencer: register upload, frame and row
 * sequencing in every readout mode, with expected values from a table.
 * Assumes the controller model drives all pins of the slow side.
 */
`timescale 1ns/1ps
`include "rss_defines.svh"
module tb_top;
    logic        clk = 1'h0;
    logic        rst_n = 1'h0;
    logic [11:0] expo = 12'h005;
    logic        dual = 1'h0;
    logic        sclk, sdata, load, fstart, rclk;
    logic [11:0] rd_row, rs_row, w;
    logic        both, sel, ssig, srst, rrst, shut, low, cload, bs;
    logic        nd, fcal, lcal, prech, glo, ghi, dark, rall;
    logic [1:0]  var_b;
    logic [10:0] pairs, pc;
    logic [3:0]  c_sig, c_rrst, c_srst, c_shut, c_low, c_col, c_sel;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    wire  [10:0] ctl = {rall, dark, ghi, glo, prech, lcal, fcal, var_b, nd, both};
    wire  [23:0] cnt = {c_sig, c_rrst, c_srst, c_shut, c_low, c_col};
    // Control word, dual slope, strobe counts {sig,rrst,srst,shut,low,col}
    localparam logic [36:0] TBL [0:8] = '{
        {12'h100, 1'h0, 24'h555501}, {12'h100, 1'h1, 24'h555551},
        {12'h108, 1'h0, 24'h5A5501}, {12'h110, 1'h0, 24'h555001},
        {12'h102, 1'h0, 24'h555501}, {12'h101, 1'h0, 24'h055001},
        {12'h103, 1'h1, 24'h500001}, {12'h105, 1'h0, 24'h055001},
        {12'h107, 1'h0, 24'h500001}};

    always #5 clk = ~clk;

    rss_ctrl_model rss_ctrl_model_inst (.clk_in(clk), .sclk_out(sclk), .sdata_out(sdata),
        .load_out(load), .fstart_out(fstart), .rclk_out(rclk));

    rss_top rss_top_inst (.CLK_IN(clk), .RESET_N_IN(rst_n), .SER_CLK_IN(sclk),
        .SER_DATA_IN(sdata), .SER_LOAD_IN(load), .FRAME_START_IN(fstart),
        .ROW_CLOCK_IN(rclk), .EXPOSURE_ROWS_IN(expo), .DUAL_SLOPE_IN(dual),
        .READ_ROW_OUT(rd_row), .RESET_ROW_OUT(rs_row), .BOTH_SIDES_OUT(both),
        .ROW_SELECT_OUT(sel), .SAMPLE_SIGNAL_OUT(ssig), .SAMPLE_RESET_OUT(srst),
        .READ_ROW_RESET_OUT(rrst), .SHUTTER_RESET_OUT(shut), .LOW_RESET_LEVEL_OUT(low),
        .COLUMN_LOAD_OUT(cload), .ROW_PIXEL_PAIR_COUNT_OUT(pairs),
        .NONDESTRUCTIVE_SELECT_OUT(nd), .MULTI_READ_VARIANT_OUT(var_b),
        .FRAME_CAL_SLOW_OUT(fcal), .LINE_CAL_SLOW_OUT(lcal),
        .CONTINUOUS_PRECHARGE_OUT(prech), .COLUMN_CLOCK_GRANULARITY_LOW_OUT(glo),
        .COLUMN_CLOCK_GRANULARITY_HIGH_OUT(ghi), .DARK_REFERENCE_OUT(dark),
        .RESET_ALL_PIXELS_OUT(rall));
////////////////////////////////////////////////////////////////////////
    function automatic logic [10:0] ectl(input logic [11:0] v);
        return {v[11:5], v[2:0], v[4] | v[0]};
    endfunction

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Window covers longest blanking
    task automatic row_run();
        fork
            rss_ctrl_model_inst.row();
            begin
                {c_sig, c_rrst, c_srst, c_shut, c_low, c_col, c_sel} = '0;
                pc = 11'h7FF;
                repeat (45) begin
                    @(negedge clk);
                    c_sig  = c_sig + 4'(ssig);
                    c_rrst = c_rrst + 4'(rrst);
                    c_srst = c_srst + 4'(srst);
                    c_shut = c_shut + 4'(shut);
                    c_low  = c_low + 4'(low);
                    c_col  = c_col + 4'(cload);
                    c_sel  = c_sel + 4'(sel & ~(ssig | srst | rrst));
                    if (cload === 1'h1) pc = pairs;
                end
                @(posedge clk);
            end
        join
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        n_mismatch++;
        $display("[ERR] t=%0t run did not finish", $time);
        test_done();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        repeat (6) @(posedge clk);
        chk(ctl, ectl(12'h100));
        chk({rd_row, rs_row, pairs}, 35'h0);
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            rss_ctrl_model_inst.wr(4'h0, 12'h001 << i);
            chk(ctl, ectl(12'h001 << i));
        end
        rss_ctrl_model_inst.wr(4'hD, 12'hFFF);
        chk(ctl, ectl(12'h800));
        $display("test register walk done");
        rss_ctrl_model_inst.wr(4'h0, 12'h100);
        rss_ctrl_model_inst.fs();
        row_run();
        chk(pc, 11'h200);
        rss_ctrl_model_inst.wr(4'h1, 12'h455);
        for (int k = 0; k < 9; k++) begin
            w  = TBL[k][36:25];
            bs = w[4] | w[0];
            rss_ctrl_model_inst.wr(4'h0, w);
            dual <= TBL[k][24];
            rss_ctrl_model_inst.fs();
            chk({rd_row, rs_row}, {12'h000, bs ? 12'h000 : expo});
            row_run();
            chk({rd_row, rs_row}, {12'h001, bs ? 12'h001 : expo + 12'h001});
            chk(cnt, TBL[k][23:0]);
            chk(c_sel, 4'h0);
            chk(pc, 11'h455);
        end
        $display("test modes done");
        test_done();
    end
endmodule
